// File: design/scir_pkg.sv
package scir_pkg;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_RHR = 8'h18;
  localparam logic [7:0] OFF_THR = 8'h1c;
  localparam logic [7:0] OFF_BAUD = 8'h20;
  localparam logic [7:0] OFF_ERR = 8'h44;
  localparam logic [7:0] OFF_FILT = 8'h4c;
  localparam logic [3:0] MODE_T0 = 4'h4;
  localparam logic [3:0] MODE_T1 = 4'h5;
  localparam logic [3:0] MODE_IRDA = 4'h8;
  localparam int CFG_MODE = 0;
  localparam int CFG_INHIBIT = 8;
  localparam int CFG_SUCCESSIVE_NACK_LIMIT = 9;
  localparam int CFG_STOP2 = 10;
  localparam int CFG_ITER = 12;
  localparam int CMD_RST_STAT = 2;
  localparam int CMD_RX_EN = 4;
  localparam int CMD_RX_DIS = 5;
  localparam int CMD_TX_EN = 6;
  localparam int CMD_TX_DIS = 7;
  localparam int CMD_CLR_ITER = 10;
  localparam int CMD_CLR_INH = 11;
  localparam int ST_RECEIVE_READY_FLAG = 0;
  localparam int ST_TXRDY = 1;
  localparam int ST_PARITY_ERROR_FLAG = 7;
  localparam int ST_TXEMPTY = 9;
  localparam int ST_ITER = 10;
  localparam int ST_INHIBIT = 13;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam logic [7:0] FILT_RESET = 8'h00;
  localparam logic [7:0] ERR_MAX = 8'hff;
  localparam logic [19:0] BIT_SUBDIV = 20'h00010;
  localparam logic [19:0] PULSE_16THS = 20'h00003;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010, TX_PAR = 3'b011,
    TX_STOP = 3'b100, TX_GUARD = 3'b101
  } scir_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_PAR = 3'b011,
    RX_STOP = 3'b100, RX_NACK = 3'b101
  } scir_rx_e;
endpackage

// File: design/scir_channel.sv
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module scir_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic txd_in,
  output logic txd_out,
  output logic txd_oe,
  output logic sck
);
  logic [15:0] cfg;
  logic [15:0] baud;
  logic [7:0] filt;
  logic [7:0] rhr;
  logic [7:0] thr;
  logic [7:0] err_cnt;
  logic thr_full, tx_en, rx_en;
  logic receive_ready_flag, parity_error_flag, iter_flag, nack_inhibit_flag;
  logic [1:0] rxd_sync, io_sync;
  scir_pkg::scir_tx_e tx_state;
  scir_pkg::scir_rx_e rx_state;
  logic [19:0] tcnt, rcnt, dhold;
  logic [2:0] tbit, rbit, iter_cnt, nack_cnt;
  logic [7:0] tshift, rshift, fcnt;
  logic nack_seen, perr;
  logic [15:0] bdiv;
  logic next_out, next_oe, tx_bit;

  wire [3:0] mode = cfg[scir_pkg::CFG_MODE +: 4];
  wire t0 = mode == scir_pkg::MODE_T0;
  wire sc = t0 || mode == scir_pkg::MODE_T1;
  wire irda = mode == scir_pkg::MODE_IRDA;
  wire [2:0] max_iter = cfg[scir_pkg::CFG_ITER +: 3];
  wire [15:0] baud_eff = (baud == 16'h0000) ? 16'h0001 : baud;
  wire [19:0] bit_len = 20'(baud_eff) * scir_pkg::BIT_SUBDIV;
  wire [19:0] half = bit_len >> 1;
  wire [19:0] pulse_len = 20'(baud_eff) * scir_pkg::PULSE_16THS;
  wire t_end = tcnt == bit_len - 20'h00001;
  wire r_end = rcnt == bit_len - 20'h00001;
  wire r_mid = rcnt == half;
  wire demod = dhold == 20'h00000;
  // In smart-card mode the shared line feeds the receiver; the block must not be
  // enabled in both directions at once or it hears its own characters.
  wire rx_line = sc ? io_sync[1] : (irda ? demod : rxd_sync[1]);

  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire cmd_wr = wr && paddr == scir_pkg::OFF_CMD;
  wire [7:0] rd_err_val = (rd && paddr == scir_pkg::OFF_ERR) ? prdata[7:0] : 8'h00;

  wire tx_take = tx_state == scir_pkg::TX_IDLE && tx_en && thr_full;
  wire g_end = tx_state == scir_pkg::TX_GUARD && t_end && tbit == (nack_seen ? 3'd2 : 3'd1);
  wire resend = nack_seen && max_iter != 3'd0 && iter_cnt < max_iter;
  wire tx_iter_hit = g_end && nack_seen && max_iter != 3'd0 && iter_cnt == max_iter;

  wire par_done = rx_state == scir_pkg::RX_PAR && r_end;
  wire t0_bad = par_done && t0 && perr;
  wire inh = cfg[scir_pkg::CFG_INHIBIT];
  wire lim_hit = cfg[scir_pkg::CFG_SUCCESSIVE_NACK_LIMIT] && nack_cnt == max_iter;
  wire rx_nack_go = t0_bad && !inh && !lim_hit;
  wire plain_done = rx_state == scir_pkg::RX_DATA && r_end && rbit == 3'd7 && !sc;
  wire rx_load = plain_done || (par_done && !rx_nack_go);
  wire ready_set = rx_load && !(t0_bad && inh);
  wire parity_error_flag_set = par_done && perr && !(t0 && (inh || lim_hit));
  wire nack_inhibit_set = t0_bad && inh;
  wire iter_rx_set = t0_bad && !inh && lim_hit;

  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_sync <= 2'b11;
      io_sync <= 2'b11;
    end else begin
      rxd_sync <= {rxd_sync[0], rxd};
      io_sync <= {io_sync[0], txd_in};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      unique case (paddr)
        scir_pkg::OFF_CMD, scir_pkg::OFF_THR: prdata <= 32'h00000000;
        scir_pkg::OFF_CFG: prdata <= 32'(cfg);
        scir_pkg::OFF_STAT: begin
          prdata[scir_pkg::ST_RECEIVE_READY_FLAG] <= receive_ready_flag;
          prdata[scir_pkg::ST_TXRDY] <= !thr_full;
          prdata[scir_pkg::ST_PARITY_ERROR_FLAG] <= parity_error_flag;
          prdata[scir_pkg::ST_TXEMPTY] <= !thr_full && tx_state == scir_pkg::TX_IDLE;
          prdata[scir_pkg::ST_ITER] <= iter_flag;
          prdata[scir_pkg::ST_INHIBIT] <= nack_inhibit_flag;
        end
        scir_pkg::OFF_RHR: prdata <= 32'(rhr);
        scir_pkg::OFF_BAUD: prdata <= 32'(baud);
        scir_pkg::OFF_ERR: prdata <= 32'(err_cnt);
        scir_pkg::OFF_FILT: prdata <= 32'(filt);
        default: pslverr <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= scir_pkg::CFG_RESET;
      baud <= scir_pkg::BAUD_RESET;
      filt <= scir_pkg::FILT_RESET;
      tx_en <= 1'b0;
      rx_en <= 1'b0;
    end else if (wr) begin
      if (paddr == scir_pkg::OFF_CFG) cfg <= pwdata[15:0];
      if (paddr == scir_pkg::OFF_BAUD) baud <= pwdata[15:0];
      if (paddr == scir_pkg::OFF_FILT) filt <= pwdata[7:0];
      if (cmd_wr && pwdata[scir_pkg::CMD_TX_EN]) tx_en <= 1'b1;
      if (cmd_wr && pwdata[scir_pkg::CMD_TX_DIS]) tx_en <= 1'b0;
      if (cmd_wr && pwdata[scir_pkg::CMD_RX_EN]) rx_en <= 1'b1;
      if (cmd_wr && pwdata[scir_pkg::CMD_RX_DIS]) rx_en <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr <= 8'h00;
      thr_full <= 1'b0;
    end else if (wr && paddr == scir_pkg::OFF_THR && !thr_full) begin
      thr <= pwdata[7:0];
      thr_full <= 1'b1;
    end else if (tx_take) begin
      thr_full <= 1'b0;
    end
  end

  // Status flags: a hardware set always beats a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_ready_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      iter_flag <= 1'b0;
      nack_inhibit_flag <= 1'b0;
      rhr <= 8'h00;
    end else begin
      if (rx_load) rhr <= rshift;
      if (ready_set) receive_ready_flag <= 1'b1;
      else if (rd && paddr == scir_pkg::OFF_RHR) receive_ready_flag <= 1'b0;
      if (parity_error_flag_set) parity_error_flag <= 1'b1;
      else if (cmd_wr && pwdata[scir_pkg::CMD_RST_STAT]) parity_error_flag <= 1'b0;
      if (tx_iter_hit || iter_rx_set) iter_flag <= 1'b1;
      else if (cmd_wr && pwdata[scir_pkg::CMD_CLR_ITER]) iter_flag <= 1'b0;
      if (nack_inhibit_set) nack_inhibit_flag <= 1'b1;
      else if (cmd_wr && pwdata[scir_pkg::CMD_CLR_INH]) nack_inhibit_flag <= 1'b0;
    end
  end

  // Subtracting the value read keeps an error that lands between setup and access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt <= 8'h00;
    end else if (par_done && perr && err_cnt - rd_err_val != scir_pkg::ERR_MAX) begin
      err_cnt <= err_cnt - rd_err_val + 8'h01;
    end else begin
      err_cnt <= err_cnt - rd_err_val;
    end
  end

  // Card clock: half period of one divisor step, eight card clocks per bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bdiv <= 16'h0000;
      sck <= 1'b0;
    end else if (bdiv >= baud_eff - 16'h0001) begin
      bdiv <= 16'h0000;
      sck <= sc ? !sck : 1'b0;
    end else begin
      bdiv <= bdiv + 16'h0001;
      if (!sc) sck <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt <= 8'h00;
      dhold <= 20'h00000;
    end else begin
      if (dhold != 20'h00000) dhold <= dhold - 20'h00001;
      // The filter keeps counting while a stretched low is still held, so a zero that
      // follows a zero straight away is not lost.
      if (rxd_sync[1]) begin
        fcnt <= filt;
      end else if (fcnt == 8'h00) begin
        dhold <= bit_len;
        fcnt <= filt;
      end else begin
        fcnt <= fcnt - 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= scir_pkg::TX_IDLE;
      tcnt <= 20'h00000;
      tbit <= 3'd0;
      tshift <= 8'h00;
      iter_cnt <= 3'd0;
      nack_seen <= 1'b0;
    end else begin
      tcnt <= (t_end || tx_state == scir_pkg::TX_IDLE) ? 20'h00000 : tcnt + 20'h00001;
      unique case (tx_state)
        scir_pkg::TX_IDLE: if (tx_take) begin
          tshift <= thr;
          tx_state <= scir_pkg::TX_START;
        end
        scir_pkg::TX_START: if (t_end) begin
          tbit <= 3'd0;
          tx_state <= scir_pkg::TX_DATA;
        end
        scir_pkg::TX_DATA: if (t_end) begin
          tbit <= tbit + 3'd1;
          if (tbit == 3'd7) tx_state <= sc ? scir_pkg::TX_PAR : scir_pkg::TX_STOP;
        end
        scir_pkg::TX_PAR: if (t_end) begin
          tbit <= 3'd0;
          nack_seen <= 1'b0;
          tx_state <= t0 ? scir_pkg::TX_GUARD : scir_pkg::TX_STOP;
        end
        scir_pkg::TX_STOP: if (t_end) begin
          tbit <= tbit + 3'd1;
          if (mode == scir_pkg::MODE_T1 || !cfg[scir_pkg::CFG_STOP2] || tbit == 3'd1)
            tx_state <= scir_pkg::TX_IDLE;
        end
        scir_pkg::TX_GUARD: begin
          if (tbit == 3'd0 && tcnt == half && !io_sync[1]) nack_seen <= 1'b1;
          if (g_end && resend) begin
            iter_cnt <= iter_cnt + 3'd1;
            tx_state <= scir_pkg::TX_START;
          end else if (g_end) begin
            iter_cnt <= 3'd0;
            tx_state <= scir_pkg::TX_IDLE;
          end else if (t_end) begin
            tbit <= tbit + 3'd1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= scir_pkg::RX_IDLE;
      rcnt <= 20'h00000;
      rbit <= 3'd0;
      rshift <= 8'h00;
      perr <= 1'b0;
      nack_cnt <= 3'd0;
    end else begin
      rcnt <= (r_end || rx_state == scir_pkg::RX_IDLE) ? 20'h00000 : rcnt + 20'h00001;
      if (rx_nack_go) nack_cnt <= nack_cnt + 3'd1;
      else if (par_done) nack_cnt <= 3'd0;
      unique case (rx_state)
        scir_pkg::RX_IDLE: if (rx_en && !rx_line) rx_state <= scir_pkg::RX_START;
        scir_pkg::RX_START: begin
          if (r_mid && rx_line) rx_state <= scir_pkg::RX_IDLE;
          else if (r_end) begin
            rbit <= 3'd0;
            rx_state <= scir_pkg::RX_DATA;
          end
        end
        scir_pkg::RX_DATA: begin
          if (r_mid) rshift[rbit] <= rx_line;
          if (r_end) begin
            rbit <= rbit + 3'd1;
            if (rbit == 3'd7) rx_state <= sc ? scir_pkg::RX_PAR : scir_pkg::RX_STOP;
          end
        end
        scir_pkg::RX_PAR: begin
          if (r_mid) perr <= rx_line ^ (^rshift);
          if (r_end) rx_state <= rx_nack_go ? scir_pkg::RX_NACK : scir_pkg::RX_STOP;
        end
        scir_pkg::RX_STOP: if (r_end) rx_state <= scir_pkg::RX_IDLE;
        scir_pkg::RX_NACK: if (r_end) rx_state <= scir_pkg::RX_STOP;
      endcase
    end
  end

  always_comb begin
    tx_bit = 1'b1;
    unique case (tx_state)
      scir_pkg::TX_START: tx_bit = 1'b0;
      scir_pkg::TX_DATA: tx_bit = tshift[tbit];
      scir_pkg::TX_PAR: tx_bit = ^tshift;
      default: tx_bit = 1'b1;
    endcase
    next_out = tx_bit;
    next_oe = 1'b1;
    if (irda) begin
      // The emitter is lit only for the first three sixteenths of a zero bit.
      next_out = !tx_bit && tx_state != scir_pkg::TX_IDLE && tcnt < pulse_len;
    end else if (sc) begin
      next_oe = tx_state inside {scir_pkg::TX_START, scir_pkg::TX_DATA, scir_pkg::TX_PAR}
                || rx_state == scir_pkg::RX_NACK;
      next_out = (rx_state == scir_pkg::RX_NACK) ? 1'b0 : tx_bit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_out <= 1'b1;
      txd_oe <= 1'b0;
    end else begin
      txd_out <= next_out;
      txd_oe <= next_oe;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_guard_release: assert property ((tx_state == scir_pkg::TX_GUARD && rx_state != scir_pkg::RX_NACK) |=> !txd_oe) else $error("line driven in guard time");
  a_nack_drive: assert property (rx_nack_go |=> rx_state == scir_pkg::RX_NACK ##1 (txd_oe && !txd_out)) else $error("no nack driven");
  a_bad_dropped: assert property (rx_nack_go |=> ($stable(rhr) && parity_error_flag)) else $error("bad character stored");
  a_count_hold: assert property ((err_cnt == scir_pkg::ERR_MAX && rd_err_val == 8'h00) |=> err_cnt == scir_pkg::ERR_MAX) else $error("error count wrapped");
  a_inhibit_quiet: assert property (nack_inhibit_set |=> (nack_inhibit_flag && rx_state == scir_pkg::RX_STOP)) else $error("inhibit not honoured");
  a_inhibit_store: assert property (nack_inhibit_set |=> (rhr == $past(rshift) && !$rose(receive_ready_flag))) else $error("inhibited character wrong");
  a_no_repeat: assert property ((g_end && nack_seen && max_iter == 3'd0) |=> tx_state == scir_pkg::TX_IDLE) else $error("repeat with zero limit");
  a_repeat_start: assert property ((g_end && resend) |=> (tx_state == scir_pkg::TX_START && iter_cnt == $past(iter_cnt) + 3'd1)) else $error("no repeat");
  a_iter_clear: assert property ((cmd_wr && pwdata[scir_pkg::CMD_CLR_ITER] && !tx_iter_hit && !iter_rx_set) |=> !iter_flag) else $error("iteration flag kept");
  a_limit_ack: assert property (iter_rx_set |=> (iter_flag && receive_ready_flag && rx_state == scir_pkg::RX_STOP)) else $error("limit not accepted");
  a_irda_dark: assert property ((irda && tx_state == scir_pkg::TX_DATA && tshift[tbit]) |=> !txd_out) else $error("light on for a one");
  a_sc_parity: assert property ((sc && tx_state == scir_pkg::TX_PAR) |=> txd_out == ^$past(tshift)) else $error("parity not even");

  c_nack_sent: cover property (rx_state == scir_pkg::RX_NACK);
  c_repeat: cover property (g_end && resend);
  c_inhibit: cover property (nack_inhibit_set);
  c_demod_pulse: cover property (irda && $rose(dhold != 20'h00000));
endmodule // scir_channel

// File: testbench/scir_card.sv
`timescale 1ns/1ps
module scir_card #(
  parameter int BIT = 32
) (
  input wire logic pclk,
  input wire logic line,
  output logic card_out,
  output logic card_oe,
  output logic guard_mid
);
  int nack_left = 0;
  int rx_count = 0;
  logic listen = 1'b1;
  logic sending = 1'b0;
  logic nack_seen = 1'b0;
  logic nack;
  logic [7:0] rx_byte = 8'h00;
  logic [8:0] sh;
  initial begin
    card_out = 1'b0;
    card_oe = 1'b0;
    guard_mid = 1'b0;
  end
  // Refusals beyond real parity faults happen only when a scenario loads nack_left.
  always begin
    @(posedge pclk);
    if (line === 1'b0 && listen && !sending) begin
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge pclk);
        sh[i] = line;
      end
      rx_byte = sh[7:0];
      rx_count++;
      nack = (^sh) || (nack_left > 0);
      if (nack_left > 0) nack_left--;
      repeat (BIT / 2) @(posedge pclk);
      card_out <= 1'b0;
      card_oe <= nack;
      repeat (BIT / 2) @(posedge pclk);
      guard_mid <= 1'b1;
      @(posedge pclk);
      guard_mid <= 1'b0;
      repeat (BIT / 2 - 1) @(posedge pclk);
      card_oe <= 1'b0;
    end
  end
  task automatic send(input logic [7:0] d, input logic bad);
    logic [9:0] f;
    f = {(^d) ^ bad, d, 1'b0};
    sending = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      card_oe <= 1'b1;
      card_out <= f[i];
      repeat (BIT - 1) @(posedge pclk);
    end
    @(posedge pclk);
    card_oe <= 1'b0;
    repeat (BIT / 2) @(posedge pclk);
    nack_seen = (line === 1'b0);
    repeat (2 * BIT) @(posedge pclk);
    sending = 1'b0;
  endtask
endmodule  // scir_card

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int DIV = 2;
  localparam int BIT = 16 * DIV;
  localparam int LIMIT = 60000;
  logic pclk, presetn, psel, penable, pwrite, rxd;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic pready, pslverr, txd_out, txd_oe, sck, card_out, card_oe, guard_mid, line, rerr;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int sck_edges = 0;
  // The card side has a pull-up, so a released line reads high.
  assign line = txd_oe ? txd_out : (card_oe ? card_out : 1'b1);
  scir_channel scir_channel_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd_in(line), .txd_out(txd_out),
    .txd_oe(txd_oe), .sck(sck));
  scir_card #(.BIT(BIT)) scir_card_inst (.pclk(pclk), .line(line), .card_out(card_out),
    .card_oe(card_oe), .guard_mid(guard_mid));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [15:0] v);
    apb(1'b1, scir_pkg::OFF_CFG, {16'h0000, v});
  endtask
  task automatic cmd(input int b);
    apb(1'b1, scir_pkg::OFF_CMD, 32'h1 << b);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic st(input int b, input logic e);
    rd(scir_pkg::OFF_STAT);
    check(rdata[b], e);
  endtask
  task automatic thr(input logic [7:0] d, input int nacks);
    scir_card_inst.nack_left = nacks;
    apb(1'b1, scir_pkg::OFF_THR, {24'h0, d});
  endtask
  // Waits past any repeat that should not come, then counts what arrived.
  task automatic wait_rx(input int n);
    while (scir_card_inst.rx_count < n) @(posedge pclk);
    repeat (16 * BIT) @(posedge pclk);
    check(scir_card_inst.rx_count, n);
  endtask
  task automatic t_regs();
    check({txd_oe, sck}, 2'b10);
    rd(scir_pkg::OFF_CFG);
    check(rdata, 32'h0);
    rd(scir_pkg::OFF_FILT);
    check(rdata, 32'h0);
    rd(8'h30);
    check(rerr, 1'b1);
    check(rdata, 32'h0);
    apb(1'b1, scir_pkg::OFF_BAUD, DIV);
    rd(scir_pkg::OFF_BAUD);
    check(rdata, DIV);
  endtask
  task automatic t_t0_tx();
    cfg({12'h000, scir_pkg::MODE_T0});
    cmd(scir_pkg::CMD_TX_EN);
    thr(8'ha5, 0);
    wait_rx(1);
    check(scir_card_inst.rx_byte, 8'ha5);
    check(32'(sck_edges != 0), 32'h1);
    thr(8'h5a, 1);
    wait_rx(2);
    st(scir_pkg::ST_ITER, 1'b0);
    cfg({12'h200, scir_pkg::MODE_T0});
    thr(8'hc3, 3);
    wait_rx(5);
    st(scir_pkg::ST_ITER, 1'b1);
    cmd(scir_pkg::CMD_CLR_ITER);
    st(scir_pkg::ST_ITER, 1'b0);
    thr(8'h3c, 1);
    wait_rx(7);
    st(scir_pkg::ST_ITER, 1'b0);
    check(scir_card_inst.rx_byte, 8'h3c);
    cmd(scir_pkg::CMD_TX_DIS);
  endtask
  task automatic t_t0_rx();
    cmd(scir_pkg::CMD_RX_EN);
    scir_card_inst.send(8'h3c, 1'b0);
    check(scir_card_inst.nack_seen, 1'b0);
    st(scir_pkg::ST_RECEIVE_READY_FLAG, 1'b1);
    rd(scir_pkg::OFF_RHR);
    check(rdata, 32'h3c);
    scir_card_inst.send(8'h96, 1'b1);
    check(scir_card_inst.nack_seen, 1'b1);
    st(scir_pkg::ST_RECEIVE_READY_FLAG, 1'b0);
    st(scir_pkg::ST_PARITY_ERROR_FLAG, 1'b1);
    rd(scir_pkg::OFF_RHR);
    check(rdata, 32'h3c);
    rd(scir_pkg::OFF_ERR);
    check(rdata, 32'h1);
    rd(scir_pkg::OFF_ERR);
    check(rdata, 32'h0);
    cmd(scir_pkg::CMD_RST_STAT);
    cfg({12'h010, scir_pkg::MODE_T0});
    scir_card_inst.send(8'h69, 1'b1);
    check(scir_card_inst.nack_seen, 1'b0);
    st(scir_pkg::ST_INHIBIT, 1'b1);
    st(scir_pkg::ST_RECEIVE_READY_FLAG, 1'b0);
    rd(scir_pkg::OFF_RHR);
    check(rdata, 32'h69);
    cmd(scir_pkg::CMD_CLR_INH);
    st(scir_pkg::ST_INHIBIT, 1'b0);
    cfg({12'h120, scir_pkg::MODE_T0});
    scir_card_inst.send(8'h11, 1'b1);
    check(scir_card_inst.nack_seen, 1'b1);
    scir_card_inst.send(8'h11, 1'b1);
    check(scir_card_inst.nack_seen, 1'b0);
    st(scir_pkg::ST_ITER, 1'b1);
    st(scir_pkg::ST_RECEIVE_READY_FLAG, 1'b1);
    cmd(scir_pkg::CMD_CLR_ITER);
    cmd(scir_pkg::CMD_RST_STAT);
    cfg({12'h000, scir_pkg::MODE_T1});
    scir_card_inst.send(8'h22, 1'b1);
    st(scir_pkg::ST_PARITY_ERROR_FLAG, 1'b1);
    rd(scir_pkg::OFF_RHR);
    check(rdata, 32'h22);
    cmd(scir_pkg::CMD_RX_DIS);
  endtask
  task automatic t_irda();
    int rises;
    int highs;
    logic [9:0] f;
    logic prev;
    rises = 0;
    highs = 0;
    prev = 1'b0;
    scir_card_inst.listen = 1'b0;
    cfg({12'h000, scir_pkg::MODE_IRDA});
    cmd(scir_pkg::CMD_TX_EN);
    thr(8'hfe, 0);
    repeat (12 * BIT) begin
      @(posedge pclk);
      highs += int'(txd_out);
      rises += int'(txd_out && !prev);
      prev = txd_out;
    end
    check(rises, 2);
    check(highs, 6 * DIV);
    cmd(scir_pkg::CMD_TX_DIS);
    apb(1'b1, scir_pkg::OFF_FILT, 32'h4);
    cmd(scir_pkg::CMD_RX_EN);
    f = {1'b1, 8'h35, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (3 * DIV) @(posedge pclk);
      rxd <= 1'b1;
      repeat (BIT - 3 * DIV) @(posedge pclk);
    end
    repeat (BIT) @(posedge pclk);
    check(txd_out, 1'b0);
    rd(scir_pkg::OFF_RHR);
    check(rdata, 32'h35);
  endtask
  always @(posedge pclk) begin
    if (guard_mid) check(txd_oe, 1'b0);
  end
  always @(posedge sck) sck_edges++;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rxd = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_t0_tx();
    t_t0_rx();
    t_irda();
    stop_test();
  end
endmodule  // tb
